// ==== pdm_params.svh ====
// Constants for the power-down mode controller: register layout and timing.
`ifndef PDM_PARAMS_SVH
`define PDM_PARAMS_SVH
`define PDM_ADDR_W 4
`define PDM_OFS_CTRL 4'h0
`define PDM_OFS_STAT 4'h1
`define PDM_OFS_WAKE 4'h2
`define PDM_CTRL_MODE_LSB 0
`define PDM_CTRL_PLLEN_BIT 2
`define PDM_CTRL_OSCEN_BIT 3
`define PDM_CTRL_RST 8'h0c
`define PDM_WATCHDOG_CLK_HZ 16000
`define PDM_REF_HZ 125000000
`define PDM_WD_DIV ((`PDM_REF_HZ) / (`PDM_WATCHDOG_CLK_HZ))
`endif

// ==== pdm_pkg.sv ====
// Types for the power-down mode controller.
`default_nettype none
package pdm_pkg;
    typedef enum logic [1:0] {
        PDM_LIGHT_IDLE = 2'b00,
        PDM_DEEP_IDLE = 2'b01,
        PDM_PLL_OFF = 2'b10,
        PDM_OSC_OFF = 2'b11
    } pdm_mode_type;
    typedef enum logic [2:0] {
        PDM_ST_RUN = 3'b000,
        PDM_ST_SLEEP = 3'b001,
        PDM_ST_OSC_WAIT = 3'b010,
        PDM_ST_PLL_WAIT = 3'b011,
        PDM_ST_HALTED = 3'b100
    } pdm_state_type;
    typedef struct packed {
        logic cpu;
        logic sys;
        logic wdog;
        logic pll;
        logic osc;
    } pdm_clk_en_type;
    typedef struct packed {
        logic reset;
        logic nmi;
        logic ext_unmasked;
        logic ext_masked;
        logic periph;
        logic wdog_rst;
    } pdm_wake_type;
endpackage
`default_nettype wire

// ==== pdm_ctrl.sv ====
// Power-down mode controller: idle entry, clock gating and wakeup.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_params.svh"
module pdm_ctrl
    import pdm_pkg::*;
#(
    parameter int WD_DIV = `PDM_WD_DIV
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [`PDM_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic cpu_idle_exec,
    input wire logic global_int_mask_bit,
    input wire logic ext_reset_pin_n,
    input wire logic nmi_pin_n,
    input wire logic ext_int_pin_n,
    input wire logic ext_int_enable,
    input wire logic periph_int_clocked,
    input wire logic periph_wake_int,
    input wire logic sw_int,
    input wire logic wdog_timeout,
    input wire logic osc_ready,
    input wire logic pll_lock,
    output logic clk_wake_async,
    output pdm_clk_en_type clk_en,
    output logic cpu_domain_clk_en,
    output logic system_domain_clk_en,
    output logic watchdog_clk_tick,
    output logic pc_advance,
    output logic vec_reset,
    output logic vec_nmi,
    output logic vec_maskable,
    output logic cpu_halted
);

    // Pins arrive from outside the clock domain and pass two flops first.
    logic [4:0] pin_meta_r;
    logic [4:0] pin_sync_r;
    logic [4:0] pin_raw;
    assign pin_raw = {~ext_reset_pin_n, ~nmi_pin_n, ~ext_int_pin_n,
                      periph_wake_int, periph_int_clocked};
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pin_meta_r <= 5'h00;
            pin_sync_r <= 5'h00;
        end else begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
        end
    end

    pdm_wake_type wake;
    always_comb begin
        wake.reset = pin_sync_r[4];
        wake.nmi = pin_sync_r[3];
        wake.ext_unmasked = pin_sync_r[2] & ext_int_enable;
        wake.ext_masked = pin_sync_r[2] & ~ext_int_enable;
        wake.periph = pin_sync_r[0] | pin_sync_r[1];
        wake.wdog_rst = wdog_timeout;
    end

    // Control register: mode field plus PLL and oscillator power-down enables.
    logic [7:0] ctrl_r;
    pdm_mode_type mode_sel;
    assign mode_sel = pdm_mode_type'(ctrl_r[`PDM_CTRL_MODE_LSB +: 2]);
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_r <= `PDM_CTRL_RST;
        end else if (reg_wr && reg_addr == `PDM_OFS_CTRL) begin
            ctrl_r <= {4'h0, reg_wdata[3:0]};
        end
    end

    pdm_state_type state_r;
    pdm_state_type state_nxt;
    pdm_mode_type mode_r;
    logic wake_cause_r;
    logic [7:0] wake_log_r;

    // Which sources may end the latched mode; software interrupts never do.
    logic wake_ok;
    always_comb begin
        wake_ok = wake.reset | wake.nmi | wake.ext_unmasked;
        case (mode_r)
            PDM_LIGHT_IDLE: begin
                wake_ok = wake_ok | wake.wdog_rst | wake.periph;
            end
            PDM_DEEP_IDLE, PDM_PLL_OFF: begin
                wake_ok = wake_ok | wake.wdog_rst | pin_sync_r[1];
            end
            default: begin
                wake_ok = wake_ok | pin_sync_r[1];
            end
        endcase
    end

    // Anything that restarts clocks, including a masked external interrupt.
    logic restart;
    assign restart = wake_ok | wake.ext_masked;

    // Mode sequencer; the software interrupt input is deliberately unused.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PDM_ST_RUN: begin
                if (cpu_idle_exec) begin
                    state_nxt = PDM_ST_SLEEP;
                end
            end
            PDM_ST_SLEEP: begin
                if (restart) begin
                    if (mode_r == PDM_OSC_OFF && ctrl_r[`PDM_CTRL_OSCEN_BIT])
                    begin
                        state_nxt = PDM_ST_OSC_WAIT;
                    end else if (mode_r[1] && ctrl_r[`PDM_CTRL_PLLEN_BIT])
                    begin
                        state_nxt = PDM_ST_PLL_WAIT;
                    end else if (wake_ok) begin
                        state_nxt = PDM_ST_RUN;
                    end else begin
                        state_nxt = PDM_ST_HALTED;
                    end
                end
            end
            PDM_ST_HALTED: begin
                // Clocks already run here, so a full wake goes straight on;
                // re-entering the restart path would loop through the waits.
                if (wake_ok) begin
                    state_nxt = PDM_ST_RUN;
                end
            end
            PDM_ST_OSC_WAIT: begin
                if (osc_ready) begin
                    state_nxt = ctrl_r[`PDM_CTRL_PLLEN_BIT] ?
                        PDM_ST_PLL_WAIT : PDM_ST_RUN;
                end
            end
            PDM_ST_PLL_WAIT: begin
                if (pll_lock) begin
                    state_nxt = wake_cause_r ? PDM_ST_RUN : PDM_ST_HALTED;
                end
            end
            default: begin
                state_nxt = PDM_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r <= PDM_ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Mode is latched at idle so a later field write cannot change the state.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_r <= PDM_LIGHT_IDLE;
        end else if (state_r == PDM_ST_RUN && cpu_idle_exec) begin
            mode_r <= mode_sel;
        end
    end

    // Remember whether the wake was a full one or only a masked restart.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wake_cause_r <= 1'b0;
        end else if (state_r == PDM_ST_SLEEP || state_r == PDM_ST_HALTED) begin
            wake_cause_r <= wake_ok;
        end
    end

    // Clock enables per state; each is a flop so the gate never glitches.
    pdm_clk_en_type en_nxt;
    logic asleep;
    logic osc_stop;
    // On the idle edge mode_r is still stale, so the field is read through;
    // otherwise the first sleeping cycle would gate by the previous mode.
    pdm_mode_type mode_cur;
    assign mode_cur = (state_r == PDM_ST_RUN) ? mode_sel : mode_r;
    assign asleep = state_nxt == PDM_ST_SLEEP;
    assign osc_stop = asleep && mode_cur == PDM_OSC_OFF &&
                      ctrl_r[`PDM_CTRL_OSCEN_BIT];
    always_comb begin
        en_nxt.cpu = state_nxt == PDM_ST_RUN;
        en_nxt.sys = ~(asleep && mode_cur != PDM_LIGHT_IDLE) &&
                     state_nxt != PDM_ST_OSC_WAIT;
        en_nxt.wdog = ~osc_stop && state_nxt != PDM_ST_OSC_WAIT;
        en_nxt.pll = ~(asleep && mode_cur[1] && ctrl_r[`PDM_CTRL_PLLEN_BIT]) &&
                     ~(state_nxt == PDM_ST_OSC_WAIT);
        en_nxt.osc = ~osc_stop;
        if (state_nxt == PDM_ST_PLL_WAIT) begin
            en_nxt.sys = 1'b0;
        end
    end

    // Enables change only on a clock edge, so an integrated clock gate sees
    // a stable level through each whole high phase.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clk_en <= 5'h1f;
        end else begin
            clk_en <= en_nxt;
        end
    end
    assign cpu_domain_clk_en = clk_en.cpu;
    assign system_domain_clk_en = clk_en.sys;

    // Pins straight to the oscillator restart, usable with every clock stopped.
    assign clk_wake_async = ~ext_reset_pin_n | ~nmi_pin_n |
                            ~ext_int_pin_n | periph_wake_int;

    // Watchdog tick divider, stopped whenever its domain is gated.
    logic [$clog2(WD_DIV)-1:0] wd_cnt_r;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wd_cnt_r <= '0;
            watchdog_clk_tick <= 1'b0;
        end else if (clk_en.wdog) begin
            watchdog_clk_tick <= wd_cnt_r == $bits(wd_cnt_r)'(WD_DIV - 1);
            wd_cnt_r <= (wd_cnt_r == $bits(wd_cnt_r)'(WD_DIV - 1)) ?
                '0 : wd_cnt_r + 1'b1;
        end else begin
            watchdog_clk_tick <= 1'b0;
        end
    end

    // Pulses to the core: PC advance on idle, then a resume vector on any wake but a maskable one with the mask bit set.
    logic wake_done;
    assign wake_done = state_r != PDM_ST_RUN && state_nxt == PDM_ST_RUN;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pc_advance <= 1'b0;
            vec_reset <= 1'b0;
            vec_nmi <= 1'b0;
            vec_maskable <= 1'b0;
        end else begin
            pc_advance <= state_r == PDM_ST_RUN && cpu_idle_exec;
            vec_reset <= wake_done && (wake.reset || wake.wdog_rst);
            vec_nmi <= wake_done && wake.nmi && !wake.reset;
            vec_maskable <= wake_done && !wake.reset && !wake.nmi &&
                            !wake.wdog_rst && !global_int_mask_bit;
        end
    end
    assign cpu_halted = state_r != PDM_ST_RUN;

    // Sticky log of what caused the last wake; cleared by a write.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wake_log_r <= 8'h00;
        end else if (wake_done) begin
            wake_log_r <= {2'h0, wake.wdog_rst, wake.periph, wake.ext_masked,
                           wake.ext_unmasked, wake.nmi, wake.reset};
        end else if (reg_wr && reg_addr == `PDM_OFS_WAKE) begin
            wake_log_r <= 8'h00;
        end
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PDM_OFS_CTRL: reg_rdata <= ctrl_r;
                `PDM_OFS_STAT: reg_rdata <= {clk_en, state_r};
                `PDM_OFS_WAKE: reg_rdata <= wake_log_r;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // A halted core must never see its clock while asleep.
    AST_CPU_GATED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == PDM_ST_SLEEP |-> !clk_en.cpu)
        else $error("cpu clock running while asleep");
    AST_ENTRY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == PDM_ST_RUN && cpu_idle_exec |=> pc_advance)
        else $error("idle without pc advance");
    AST_DEEP_SYS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == PDM_ST_SLEEP && mode_r == PDM_DEEP_IDLE |-> !clk_en.sys)
        else $error("system clock running in deep idle");
    AST_RST_WAKE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == PDM_ST_SLEEP && wake.reset && !mode_r[1] |=>
        state_r == PDM_ST_RUN)
        else $error("reset did not end sleep");
    AST_SW_IGNORED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == PDM_ST_SLEEP && sw_int && !restart |=>
        state_r == PDM_ST_SLEEP)
        else $error("software interrupt woke the device");
    AST_MASKED_HALT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == PDM_ST_SLEEP && mode_r == PDM_LIGHT_IDLE &&
        restart && !wake_ok |=> state_r == PDM_ST_HALTED)
        else $error("masked interrupt did not halt");
    AST_PLL_WAIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == PDM_ST_PLL_WAIT && !pll_lock && !wake.reset |=>
        !clk_en.cpu)
        else $error("clock released before lock");
    AST_OSC_WD: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == PDM_ST_SLEEP && mode_r == PDM_OSC_OFF &&
        ctrl_r[`PDM_CTRL_OSCEN_BIT] |-> !clk_en.wdog && !clk_en.osc)
        else $error("clock running in oscillator off");
    AST_GLOBAL_INT_MASK_BIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        vec_maskable |-> !$past(global_int_mask_bit))
        else $error("service routine taken with mask set");

    // Oscillator restart: only the oscillator itself runs until it is ready.
    sequence seq_osc_restart;
        state_r == PDM_ST_OSC_WAIT && !osc_ready;
    endsequence
    AST_OSC_FIRST: assert property (@(posedge ref_clk) disable iff (sys_rst)
        seq_osc_restart |=> !clk_en.cpu && !clk_en.sys && !clk_en.wdog)
        else $error("clock released before oscillator start");

    // Except oscillator-off with only the oscillator enable set, a masked restart leaves every clock but the core's running.
    AST_HALT_CLOCKS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_r == PDM_ST_HALTED |-> !clk_en.cpu && clk_en.sys &&
        clk_en.wdog && clk_en.pll && clk_en.osc)
        else $error("halted state with wrong clock enables");
endmodule
`default_nettype wire

// ==== pdm_clkgen_model.sv ====
// Behavioural oscillator and PLL that follow the controller's clock enables.
`timescale 1ns/1ps
`default_nettype none
module pdm_clkgen_model
    import pdm_pkg::*;
#(
    parameter int OSC_DLY = 20,
    parameter int PLL_DLY = 10
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire pdm_clk_en_type clk_en,
    output logic osc_ready,
    output logic pll_lock
);
    int osc_cnt;
    int pll_cnt;

    // The oscillator dies at once when gated and needs OSC_DLY cycles back.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            osc_cnt <= OSC_DLY;
        end else if (!clk_en.osc) begin
            osc_cnt <= 0;
        end else if (osc_cnt < OSC_DLY) begin
            osc_cnt <= osc_cnt + 1;
        end
    end

    // Lock is lost with the PLL or its reference, so a slow relock shows up.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pll_cnt <= PLL_DLY;
        end else if (!clk_en.pll || !osc_ready) begin
            pll_cnt <= 0;
        end else if (pll_cnt < PLL_DLY) begin
            pll_cnt <= pll_cnt + 1;
        end
    end

    // Status levels seen by the controller.
    assign osc_ready = (osc_cnt >= OSC_DLY);
    assign pll_lock = (pll_cnt >= PLL_DLY);
endmodule
`default_nettype wire

// ==== test_power_down_mode_controller.sv ====
// Self-checking bench for the power-down mode controller.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_params.svh"
module test_power_down_mode_controller
    import pdm_pkg::*;
;
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] src;
        logic mask;
        logic wake;
        logic [4:0] en;
        logic [2:0] vec;
    } pdm_row_type;

    logic ref_clk, sys_rst, reg_wr, reg_rd, cpu_idle_exec;
    logic [`PDM_ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic global_int_mask_bit, ext_reset_pin_n, nmi_pin_n, ext_int_pin_n;
    logic ext_int_enable, periph_int_clocked, periph_wake_int, sw_int;
    logic wdog_timeout, osc_ready, pll_lock, clk_wake_async;
    logic cpu_domain_clk_en, system_domain_clk_en, watchdog_clk_tick;
    logic pc_advance, vec_reset, vec_nmi, vec_maskable, cpu_halted;
    pdm_clk_en_type clk_en;
    int num_errors = 0;
    int comparisons = 0;
    int ticks = 0;
    // Mode, source, mask bit, wakes, clocks while asleep, {rst,nmi,mask}.
    pdm_row_type rows [12] = '{
        '{2'h0, 3'h5, 1'b0, 1'b1, 5'h0f, 3'h1},
        '{2'h1, 3'h3, 1'b1, 1'b1, 5'h07, 3'h0},
        '{2'h2, 3'h4, 1'b0, 1'b1, 5'h05, 3'h4},
        '{2'h3, 3'h3, 1'b0, 1'b1, 5'h00, 3'h1},
        '{2'h3, 3'h0, 1'b1, 1'b1, 5'h00, 3'h4},
        '{2'h1, 3'h2, 1'b0, 1'b1, 5'h07, 3'h1},
        '{2'h2, 3'h2, 1'b1, 1'b1, 5'h05, 3'h0},
        '{2'h0, 3'h4, 1'b0, 1'b1, 5'h0f, 3'h4},
        '{2'h1, 3'h0, 1'b0, 1'b1, 5'h07, 3'h4},
        '{2'h3, 3'h4, 1'b0, 1'b0, 5'h00, 3'h0},
        '{2'h1, 3'h5, 1'b0, 1'b0, 5'h07, 3'h0},
        '{2'h0, 3'h6, 1'b0, 1'b0, 5'h0f, 3'h0}
    };

    // A short watchdog divider keeps tick counting cheap in simulation.
    pdm_ctrl #(.WD_DIV(4)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_idle_exec(cpu_idle_exec),
        .global_int_mask_bit(global_int_mask_bit),
        .ext_reset_pin_n(ext_reset_pin_n), .nmi_pin_n(nmi_pin_n),
        .ext_int_pin_n(ext_int_pin_n), .ext_int_enable(ext_int_enable),
        .periph_int_clocked(periph_int_clocked),
        .periph_wake_int(periph_wake_int), .sw_int(sw_int),
        .wdog_timeout(wdog_timeout), .osc_ready(osc_ready),
        .pll_lock(pll_lock), .clk_wake_async(clk_wake_async),
        .clk_en(clk_en), .cpu_domain_clk_en(cpu_domain_clk_en),
        .system_domain_clk_en(system_domain_clk_en),
        .watchdog_clk_tick(watchdog_clk_tick), .pc_advance(pc_advance),
        .vec_reset(vec_reset), .vec_nmi(vec_nmi),
        .vec_maskable(vec_maskable), .cpu_halted(cpu_halted));

    // Clock source and PLL answering the controller's enables.
    pdm_clkgen_model model_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .osc_ready(osc_ready), .pll_lock(pll_lock));

    // The 8 ns clock.
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic print_verdict();
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic set_src(input logic [2:0] s, input logic a);
        case (s)
            3'h0: ext_reset_pin_n <= !a;
            3'h1: nmi_pin_n <= !a;
            3'h2: ext_int_pin_n <= !a;
            3'h3: periph_wake_int <= a;
            3'h4: wdog_timeout <= a;
            3'h5: periph_int_clocked <= a;
            default: sw_int <= a;
        endcase
    endtask

    task automatic enter(input logic [1:0] mode, input logic mask);
        wr(`PDM_OFS_CTRL, {6'h03, mode});
        @(posedge ref_clk);
        global_int_mask_bit <= mask;
        cpu_idle_exec <= 1'b1;
        @(posedge ref_clk);
        cpu_idle_exec <= 1'b0;
        #1;
        chk({7'h0, pc_advance}, 8'h01);
    endtask

    // Vector pulses last one cycle, so they are gathered while waiting.
    task automatic wait_wake(output logic [2:0] v, input int lim);
        v = 3'h0;
        for (int k = 0; k < lim && cpu_halted !== 1'b0; k++) begin
            @(posedge ref_clk);
            #1;
            v = v | {vec_reset, vec_nmi, vec_maskable};
        end
    endtask

    task automatic nmi_wake();
        logic [2:0] v;
        @(posedge ref_clk);
        nmi_pin_n <= 1'b0;
        #1;
        chk({7'h0, clk_wake_async}, 8'h01);
        wait_wake(v, 2000);
        chk({5'h0, v}, 8'h02);
        @(posedge ref_clk);
        nmi_pin_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask

    // The core clock may only run on a locked PLL, the watchdog clock on a live oscillator.
    always @(posedge ref_clk) begin
        if (watchdog_clk_tick === 1'b1) ticks++;
        if (!sys_rst && clk_en.cpu === 1'b1) begin
            chk({7'h0, pll_lock}, 8'h01);
        end
        if (!sys_rst && clk_en.wdog === 1'b1) begin
            chk({7'h0, osc_ready}, 8'h01);
        end
    end

    // Main sequence: reset, register checks, the table, then odd cases.
    initial begin
        logic [7:0] d;
        logic [2:0] v;
        pdm_row_type r;
        sys_rst <= 1'b1;
        reg_addr <= 4'h0;
        reg_wdata <= 8'h00;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        cpu_idle_exec <= 1'b0;
        global_int_mask_bit <= 1'b1;
        ext_reset_pin_n <= 1'b1;
        nmi_pin_n <= 1'b1;
        ext_int_pin_n <= 1'b1;
        ext_int_enable <= 1'b1;
        periph_int_clocked <= 1'b0;
        periph_wake_int <= 1'b0;
        sw_int <= 1'b0;
        wdog_timeout <= 1'b0;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1;
        chk({3'h0, clk_en}, 8'h1f);
        rd(`PDM_OFS_CTRL, d);
        chk(d, `PDM_CTRL_RST);
        rd(`PDM_OFS_STAT, d);
        chk(d, 8'hf8);
        wr(`PDM_OFS_CTRL, 8'hff);
        rd(`PDM_OFS_CTRL, d);
        chk(d, 8'h0f);
        rd(4'h7, d);
        chk(d, 8'h00);
        for (int i = 0; i < 12; i++) begin
            r = rows[i];
            enter(r.mode, r.mask);
            chk({3'h0, clk_en}, {3'h0, r.en});
            chk({6'h0, cpu_domain_clk_en, system_domain_clk_en},
                {6'h0, r.en[4:3]});
            rd(`PDM_OFS_STAT, d);
            chk(d, {r.en, PDM_ST_SLEEP});
            @(posedge ref_clk);
            set_src(r.src, 1'b1);
            wait_wake(v, r.wake ? 2000 : 30);
            chk({7'h0, cpu_halted}, {7'h0, !r.wake});
            chk({5'h0, v}, {5'h0, r.vec});
            @(posedge ref_clk);
            set_src(r.src, 1'b0);
            if (!r.wake) begin
                nmi_wake();
            end
            repeat (6) @(posedge ref_clk);
        end
        // Watchdog ticks run in light idle and stop with the oscillator.
        for (int m = 0; m < 4; m += 3) begin
            enter(2'(m), 1'b1);
            // Skip the tick launched on the entry edge itself.
            @(posedge ref_clk);
            #1;
            ticks = 0;
            repeat (40) @(posedge ref_clk);
            #1;
            chk(8'(ticks), (m == 0) ? 8'h0a : 8'h00);
            nmi_wake();
        end
        // A masked pin wakes the clocks only; a second idle is ignored.
        // Light idle goes straight to halt; oscillator-off restarts first.
        for (int m = 0; m < 4; m += 3) begin
            enter(2'(m), 1'b0);
            @(posedge ref_clk);
            ext_int_enable <= 1'b0;
            ext_int_pin_n <= 1'b0;
            for (int k = 0; k < 2000 && clk_en !== 5'h0f; k++) begin
                @(posedge ref_clk);
            end
            repeat (4) @(posedge ref_clk);
            #1;
            chk({7'h0, cpu_halted}, 8'h01);
            chk({3'h0, clk_en}, 8'h0f);
            @(posedge ref_clk);
            cpu_idle_exec <= 1'b1;
            @(posedge ref_clk);
            cpu_idle_exec <= 1'b0;
            #1;
            chk({7'h0, pc_advance}, 8'h00);
            rd(`PDM_OFS_STAT, d);
            chk(d, {5'h0f, PDM_ST_HALTED});
            // The pin must be clear of the synchroniser before it is unmasked.
            @(posedge ref_clk);
            ext_int_pin_n <= 1'b1;
            repeat (4) @(posedge ref_clk);
            ext_int_enable <= 1'b1;
            nmi_wake();
        end
        print_verdict();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #400000;
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
